//--- pps_top.sv
// Pin control top: reset, standby, busy, oscillator pins and playback start
`timescale 1ns/1ps
module pps_top #(
   parameter int CAPTURE_CYCLES = pps_pkg::CAPTURE_CYCLES,
   parameter int POR_CYCLES     = pps_pkg::POR_CYCLES
) (
   input  wire logic                            sys_clk,
   input  wire logic                            rst_n,
   input  wire logic                            resetPin_n,
   input  wire logic                            oscTypeSelect,
   input  wire logic                            oscIn,
   input  wire logic                            randomPlay_n,
   input  wire logic [pps_pkg::HI_W-1:0]        phraseSelectHi,
   input  wire logic [pps_pkg::LO_W-1:0]        phraseSelectLo,
   input  wire logic                            programToolIf,
   input  wire logic                            phraseDone,
   input  wire logic [pps_pkg::SOUND_W-1:0]     sampleIn,
   output logic                                 busy_n,
   output logic                                 oscDriveOut,
   output logic                                 rcNetworkOut,
   output logic                                 oscEnable,
   output logic [pps_pkg::SOUND_W-1:0]          soundOut,
   output logic                                 playStart,
   output logic [pps_pkg::ADDR_W-1:0]           phraseAddr
);
   // ==========================================================
   // Pin synchronisers, one per pin bit
   localparam int NSYNC = 5 + pps_pkg::HI_W + pps_pkg::LO_W;
   logic [NSYNC-1:0] pinRaw;
   logic [NSYNC-1:0] meta_ff;
   logic [NSYNC-1:0] sync_ff;

   assign pinRaw = {resetPin_n, oscTypeSelect, oscIn, randomPlay_n, programToolIf, phraseSelectHi, phraseSelectLo};

   generate
      for (genvar i = 0; i < NSYNC; i++) begin : g_sync
         // Two flops per pin; pull-ups idle high on reset, oscillator type select, oscillator and random pins
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_ff[i] <= (i >= NSYNC - 4) ? 1'b1 : 1'b0;
               sync_ff[i] <= (i >= NSYNC - 4) ? 1'b1 : 1'b0;
            end else begin
               meta_ff[i] <= pinRaw[i];
               sync_ff[i] <= meta_ff[i];
            end
         end
      end
   endgenerate

   logic                        resetPinS_n;
   logic                        ceramicSel;
   logic                        oscInS;
   logic                        rndS_n;
   logic                        pgmS;
   logic [pps_pkg::HI_W-1:0]    hiS;
   logic [pps_pkg::LO_W-1:0]    loS;

   assign resetPinS_n = sync_ff[NSYNC-1];
   assign ceramicSel  = sync_ff[NSYNC-2];
   assign oscInS      = sync_ff[NSYNC-3];
   assign rndS_n      = sync_ff[NSYNC-4];
   assign pgmS        = sync_ff[NSYNC-5];
   assign hiS         = sync_ff[pps_pkg::LO_W +: pps_pkg::HI_W];
   assign loS         = sync_ff[pps_pkg::LO_W-1:0];

   // ==========================================================
   // Internal power-on reset hold
   localparam int POR_W = $clog2(POR_CYCLES + 1);
   logic [POR_W-1:0] porCnt_ff;
   logic             porActive;

   assign porActive = (porCnt_ff != '0);

   // Counts down from power-on before leaving standby
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         porCnt_ff <= POR_CYCLES[POR_W-1:0];
      end else if (porActive) begin
         porCnt_ff <= porCnt_ff - 1'b1;
      end
   end

   logic standbyReq;
   assign standbyReq = porActive | ~resetPinS_n;

   // ==========================================================
   // Phrase capture unit
   pps_cap_if capBus ();

   assign capBus.clear = standbyReq;
   assign capBus.hi    = hiS;
   assign capBus.lo    = loS;
   assign capBus.rndN  = rndS_n;

   pps_phrase_capture #(
      .CAPTURE_CYCLES (CAPTURE_CYCLES)
   ) u_capture (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .bus     (capBus.cap)
   );

   // ==========================================================
   // Playback state machine
   pps_pkg::pps_state_t state_ff;
   pps_pkg::pps_state_t nxt_state;
   logic                startNow;

   // Programming tool input high blocks new starts
   assign startNow = capBus.capture & ~pgmS;

   // Next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         pps_pkg::ST_STANDBY: begin
            if (!standbyReq) begin
               nxt_state = pps_pkg::ST_IDLE;
            end
         end
         pps_pkg::ST_IDLE: begin
            if (startNow) begin
               nxt_state = pps_pkg::ST_PLAY;
            end
         end
         pps_pkg::ST_PLAY: begin
            if (phraseDone) begin
               nxt_state = pps_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = pps_pkg::ST_STANDBY;
         end
      endcase
      if (standbyReq) begin
         nxt_state = pps_pkg::ST_STANDBY;
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= pps_pkg::ST_STANDBY;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Busy and playback start outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_n     <= 1'b1;
         playStart  <= 1'b0;
         phraseAddr <= '0;
      end else begin
         busy_n    <= (nxt_state != pps_pkg::ST_PLAY);
         playStart <= (state_ff == pps_pkg::ST_IDLE) && (nxt_state == pps_pkg::ST_PLAY);
         if (standbyReq) begin
            phraseAddr <= '0;
         end else if ((state_ff == pps_pkg::ST_IDLE) && startNow) begin
            phraseAddr <= capBus.addr;
         end
      end
   end

   // ==========================================================
   // Oscillator pins and sound output
   logic nxtStandby;
   assign nxtStandby = (nxt_state == pps_pkg::ST_STANDBY);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         oscEnable    <= 1'b0;
         oscDriveOut  <= 1'b0;
         rcNetworkOut <= 1'b0;
         soundOut     <= pps_pkg::SOUND_GND;
      end else if (nxtStandby) begin
         oscEnable    <= 1'b0;
         oscDriveOut  <= 1'b0;
         rcNetworkOut <= ~ceramicSel;
         soundOut     <= pps_pkg::SOUND_GND;
      end else begin
         oscEnable    <= 1'b1;
         oscDriveOut  <= ~oscInS;
         rcNetworkOut <= ~ceramicSel & oscInS;
         soundOut     <= (nxt_state == pps_pkg::ST_PLAY) ? sampleIn : pps_pkg::SOUND_GND;
      end
   end

   // ==========================================================
   // Checks
   property p_reset_pin;
      @(posedge sys_clk) disable iff (!rst_n)
      !resetPinS_n |=> (state_ff == pps_pkg::ST_STANDBY) && !oscEnable && (soundOut == 12'h000);
   endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("reset pin did not force standby");

   property p_por_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      $past(porActive) |-> (state_ff == pps_pkg::ST_STANDBY);
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("left standby during power-on hold");

   property p_busy;
      @(posedge sys_clk) disable iff (!rst_n)
      busy_n == (state_ff != pps_pkg::ST_PLAY);
   endproperty
   a_busy: assert property (p_busy) else $error("busy does not follow playback");

   property p_osc_drive_out_low;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == pps_pkg::ST_STANDBY) |-> !oscDriveOut;
   endproperty
   a_osc_drive_out_low: assert property (p_osc_drive_out_low) else $error("second oscillator output high in standby");

   property p_rc_network_out_high;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == pps_pkg::ST_STANDBY && !$past(ceramicSel)) |-> rcNetworkOut;
   endproperty
   a_rc_network_out_high: assert property (p_rc_network_out_high) else $error("third oscillator output low in RC standby");

   property p_start;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == pps_pkg::ST_IDLE && capBus.capture && !pgmS && !standbyReq)
         |=> playStart && !busy_n && (phraseAddr == $past(capBus.addr));
   endproperty
   a_start: assert property (p_start) else $error("captured phrase did not start");

   property p_pgm_block;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == pps_pkg::ST_IDLE && pgmS) |=> !playStart;
   endproperty
   a_pgm_block: assert property (p_pgm_block) else $error("start while tool input high");

   property p_done;
      @(posedge sys_clk) disable iff (!rst_n)
      (state_ff == pps_pkg::ST_PLAY && phraseDone && !standbyReq) |=> busy_n ##1 (busy_n || $past(startNow));
   endproperty
   a_done: assert property (p_done) else $error("busy not released at end of phrase");
endmodule

//--- pps_pkg.sv
// Shared constants for the phrase playback pin control block
package pps_pkg;
   // ==========================================================
   // Clock and timing
   localparam int SYS_CLK_MHZ      = 100;
   localparam int CAPTURE_DELAY_MS = 16;
   localparam int CAPTURE_CYCLES   = CAPTURE_DELAY_MS * SYS_CLK_MHZ * 1000;
   localparam int POR_TIME_US      = 1000;
   localparam int POR_CYCLES       = POR_TIME_US * SYS_CLK_MHZ;
   localparam int CNT_W            = 21;

   // ==========================================================
   // Widths and values
   localparam int HI_W             = 4;
   localparam int LO_W             = 3;
   localparam int ADDR_W           = HI_W + LO_W;
   localparam int SOUND_W          = 12;
   localparam logic [6:0] LFSR_SEED = 7'h5a;
   localparam logic [11:0] SOUND_GND = 12'h000;

   // ==========================================================
   // Playback states
   typedef enum logic [1:0] {
      ST_STANDBY = 2'b00,
      ST_IDLE    = 2'b01,
      ST_PLAY    = 2'b10
   } pps_state_t;
endpackage

//--- pps_cap_if.sv
// Carrier between the pin control top and the phrase capture unit
`timescale 1ns/1ps
interface pps_cap_if;
   logic                           clear;
   logic [pps_pkg::HI_W-1:0]       hi;
   logic [pps_pkg::LO_W-1:0]       lo;
   logic                           rndN;
   logic                           capture;
   logic [pps_pkg::ADDR_W-1:0]     addr;

   modport ctl (output clear, output hi, output lo, output rndN, input capture, input addr);
   modport cap (input clear, input hi, input lo, input rndN, output capture, output addr);
endinterface

//--- pps_phrase_capture.sv
// Phrase capture unit: delayed switch capture and random playback trigger
`timescale 1ns/1ps
module pps_phrase_capture #(
   parameter int CAPTURE_CYCLES = pps_pkg::CAPTURE_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   pps_cap_if.cap    bus
);
   // ==========================================================
   // State
   logic [pps_pkg::HI_W-1:0]   prevHi_ff;
   logic [pps_pkg::CNT_W-1:0]  timer_ff;
   logic [6:0]                 lfsr_ff;
   logic                       prevRndN_ff;
   logic                       capture_ff;
   logic                       capRandom_ff;
   logic [pps_pkg::ADDR_W-1:0] addr_ff;
   logic                       hiChange;
   logic                       rndFall;
   logic [pps_pkg::ADDR_W-1:0] switchAddr;

   assign hiChange = (bus.hi != prevHi_ff);
   assign rndFall  = prevRndN_ff & ~bus.rndN;
   // Low select bit dropped while random playback is in use
   assign switchAddr = {bus.hi, bus.lo[2:1], bus.lo[0] & bus.rndN};

   assign bus.capture = capture_ff;
   assign bus.addr    = addr_ff;

   // ==========================================================
   // Edge history of upper group and random input
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prevHi_ff   <= '0;
         prevRndN_ff <= 1'b1;
      end else if (bus.clear) begin
         prevHi_ff   <= bus.hi;
         prevRndN_ff <= 1'b1;
      end else begin
         prevHi_ff   <= bus.hi;
         prevRndN_ff <= bus.rndN;
      end
   end

   // Capture delay timer, restarted by every further change of the upper group
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_ff <= '0;
      end else if (bus.clear) begin
         timer_ff <= '0;
      end else if (hiChange) begin
         timer_ff <= CAPTURE_CYCLES[pps_pkg::CNT_W-1:0];
      end else if (timer_ff != '0) begin
         timer_ff <= timer_ff - 1'b1;
      end
   end

   // Free-running random address generator
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_ff <= pps_pkg::LFSR_SEED;
      end else if (bus.clear) begin
         lfsr_ff <= pps_pkg::LFSR_SEED;
      end else begin
         lfsr_ff <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
      end
   end

   // Capture pulse and address; random fall wins a tie
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         capture_ff   <= 1'b0;
         capRandom_ff <= 1'b0;
         addr_ff      <= '0;
      end else if (bus.clear) begin
         capture_ff   <= 1'b0;
         capRandom_ff <= 1'b0;
         addr_ff      <= '0;
      end else if (rndFall) begin
         capture_ff   <= 1'b1;
         capRandom_ff <= 1'b1;
         addr_ff      <= lfsr_ff;
      end else if (timer_ff == {{(pps_pkg::CNT_W-1){1'b0}}, 1'b1} && !hiChange) begin
         capture_ff   <= 1'b1;
         capRandom_ff <= 1'b0;
         addr_ff      <= switchAddr;
      end else begin
         capture_ff   <= 1'b0;
         capRandom_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   property p_restart;
      @(posedge sys_clk) disable iff (!rst_n)
      (hiChange && !bus.clear) |=> (timer_ff == CAPTURE_CYCLES[pps_pkg::CNT_W-1:0]);
   endproperty
   a_restart: assert property (p_restart) else $error("capture timer not restarted");

   property p_expire;
      @(posedge sys_clk) disable iff (!rst_n)
      (timer_ff == 21'h000001 && !hiChange && !rndFall && !bus.clear) |=> (capture_ff && addr_ff == $past(switchAddr));
   endproperty
   a_expire: assert property (p_expire) else $error("no capture at timer expiry");

   property p_rnd_fall;
      @(posedge sys_clk) disable iff (!rst_n)
      (rndFall && !bus.clear) |=> (capture_ff && capRandom_ff && addr_ff == $past(lfsr_ff));
   endproperty
   a_rnd_fall: assert property (p_rnd_fall) else $error("random fall did not fetch");

   property p_ignore_low;
      @(posedge sys_clk) disable iff (!rst_n)
      (capture_ff && !capRandom_ff && !$past(bus.rndN)) |-> (addr_ff[0] == 1'b0);
   endproperty
   a_ignore_low: assert property (p_ignore_low) else $error("low select bit used in random mode");
endmodule

//--- pps_far_side.sv
// Far-side model: oscillator pin and speech decoder answering each playback start
`timescale 1ns/1ps
module pps_far_side (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        playStart,
   input  wire logic [7:0]  playLen,
   output logic             phraseDone,
   output logic [11:0]      sampleIn,
   output logic             oscIn
);
   logic [7:0]  left_ff;
   logic [10:0] wave_ff;

   // ==========================================================
   // Oscillator pin and sample stream
   // Oscillator toggles every cycle; sample stream never reads as ground
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         oscIn   <= 1'b0;
         wave_ff <= 11'h000;
      end else begin
         oscIn   <= ~oscIn;
         wave_ff <= wave_ff + 11'h001;
      end
   end
   assign sampleIn = {1'b1, wave_ff};

   // ==========================================================
   // Phrase length timer
   // Done pulse arrives playLen+1 cycles after playStart for any nonzero playLen; a playLen of zero gives none
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         left_ff    <= 8'h00;
         phraseDone <= 1'b0;
      end else begin
         phraseDone <= (left_ff == 8'h01);
         if (playStart) begin
            left_ff <= playLen;
         end else if (left_ff != 8'h00) begin
            left_ff <= left_ff - 8'h01;
         end
      end
   end
endmodule

//--- pps_testbench.sv
// Self-checking testbench for the phrase playback pin control top
`timescale 1ns/1ps
module testbench;
   localparam int CAP = 20;
   logic                    sys_clk, rst_n, resetPin_n, oscTypeSelect, randomPlay_n, programToolIf;
   logic [3:0]              phraseSelectHi;
   logic [2:0]              phraseSelectLo;
   logic [7:0]              playLen;
   logic                    oscIn, phraseDone, busy_n, oscDriveOut, rcNetworkOut, oscEnable, playStart;
   logic [11:0]             sampleIn, soundOut;
   logic [6:0]              phraseAddr;
   int                      failures, compares, cycles, n;

   pps_top #(.CAPTURE_CYCLES(CAP), .POR_CYCLES(8)) dut_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .resetPin_n(resetPin_n), .oscTypeSelect(oscTypeSelect),
      .oscIn(oscIn), .randomPlay_n(randomPlay_n), .phraseSelectHi(phraseSelectHi),
      .phraseSelectLo(phraseSelectLo), .programToolIf(programToolIf), .phraseDone(phraseDone),
      .sampleIn(sampleIn), .busy_n(busy_n), .oscDriveOut(oscDriveOut), .rcNetworkOut(rcNetworkOut),
      .oscEnable(oscEnable), .soundOut(soundOut), .playStart(playStart), .phraseAddr(phraseAddr));

   pps_far_side far_u (
      .sys_clk(sys_clk), .rst_n(rst_n), .playStart(playStart), .playLen(playLen),
      .phraseDone(phraseDone), .sampleIn(sampleIn), .oscIn(oscIn));

   // ==========================================================
   // Clock and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         summarize();
      end
   end

   // ==========================================================
   // Shared helpers
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic waitStart(input int limit);
      n = 0;
      while (playStart !== 1'b1 && n < limit) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   task automatic waitFor(input int limit, input logic want);
      int k;
      k = 0;
      while (((want ? oscEnable : busy_n) !== 1'b1) && k < limit) begin
         @(negedge sys_clk);
         k++;
      end
      chk(want ? "oscEnable" : "busy_n", 12'h001, {11'h000, (want ? oscEnable : busy_n)});
   endtask
   task automatic standbyPins(input logic rcHigh);
      @(negedge sys_clk);
      chk("busy_n", 12'h001, {11'h000, busy_n});
      chk("oscEnable", 12'h000, {11'h000, oscEnable});
      chk("soundOut", 12'h000, soundOut);
      chk("oscDriveOut", 12'h000, {11'h000, oscDriveOut});
      chk("rcNetworkOut", {11'h000, rcHigh}, {11'h000, rcNetworkOut});
      chk("phraseAddr", 12'h000, {5'h00, phraseAddr});
   endtask

   // ==========================================================
   // Scenarios
   task automatic testPowerOn;
      standbyPins(1'b0);
      @(posedge sys_clk) rst_n <= 1'b1;
      step(4);
      standbyPins(1'b1);
      waitFor(40, 1'b1);
      step(4);
      $display("test power-on done");
   endtask

   task automatic testSwitch;
      @(posedge sys_clk) phraseSelectHi <= 4'ha;
      phraseSelectLo <= 3'h5;
      step(10);
      @(posedge sys_clk) phraseSelectHi <= 4'h3;
      waitStart(CAP + 8);
      chk("start delay ok", 12'h001, {11'h000, (playStart === 1'b1 && n >= CAP + 2 && n <= CAP + 6)});
      chk("phraseAddr", 12'h01d, {5'h00, phraseAddr});
      @(negedge sys_clk);
      chk("busy_n", 12'h000, {11'h000, busy_n});
      chk("soundOut msb", 12'h001, {11'h000, soundOut[11]});
      waitFor(20, 1'b0);
      chk("soundOut", 12'h000, soundOut);
      $display("test switch capture done");
   endtask

   task automatic testRandom;
      @(posedge sys_clk) phraseSelectLo <= 3'h7;
      randomPlay_n <= 1'b0;
      waitStart(8);
      chk("random start", 12'h001, {11'h000, playStart});
      @(negedge sys_clk);
      chk("busy_n", 12'h000, {11'h000, busy_n});
      waitFor(20, 1'b0);
      @(posedge sys_clk) phraseSelectHi <= 4'h6;
      waitStart(CAP + 8);
      chk("phraseAddr", 12'h036, {5'h00, phraseAddr});
      waitFor(20, 1'b0);
      @(posedge sys_clk) randomPlay_n <= 1'b1;
      step(4);
      $display("test random done");
   endtask

   task automatic testToolBlocks;
      @(posedge sys_clk) programToolIf <= 1'b1;
      phraseSelectHi <= 4'h9;
      waitStart(CAP + 10);
      chk("blocked start", 12'h000, {11'h000, playStart});
      chk("busy_n", 12'h001, {11'h000, busy_n});
      @(posedge sys_clk) programToolIf <= 1'b0;
      step(4);
      $display("test tool input done");
   endtask

   task automatic testResetPin;
      playLen <= 8'hc8;
      @(posedge sys_clk) phraseSelectHi <= 4'h2;
      waitStart(CAP + 8);
      chk("start", 12'h001, {11'h000, playStart});
      @(posedge sys_clk) resetPin_n <= 1'b0;
      step(5);
      standbyPins(1'b1);
      @(posedge sys_clk) oscTypeSelect <= 1'b1;
      step(5);
      standbyPins(1'b0);
      @(posedge sys_clk) resetPin_n <= 1'b1;
      playLen <= 8'h03;
      waitFor(60, 1'b1);
      chk("busy_n", 12'h001, {11'h000, busy_n});
      $display("test reset pin done");
   endtask

   // ==========================================================
   // Closing report
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      failures       = 0;
      compares       = 0;
      cycles         = 0;
      rst_n          = 1'b0;
      resetPin_n     = 1'b1;
      oscTypeSelect  = 1'b0;
      randomPlay_n   = 1'b1;
      programToolIf  = 1'b0;
      phraseSelectHi = 4'h0;
      phraseSelectLo = 3'h0;
      playLen        = 8'h0c;
      step(8);
      testPowerOn();
      testSwitch();
      testRandom();
      testToolBlocks();
      testResetPin();
      summarize();
   end
endmodule
